// [design/vipsq_pkg.sv]
// Purpose: constants, field layouts and helpers of the vectored interrupt sequencer
// Assumes: 32-bit classic wishbone, byte addresses on a 10-bit bus address
// Notes:   shared by the top, the resolver and the level stack
package vipsq_pkg;

  // bus geometry
  localparam int unsigned ADR_W    = 10;            // byte address width
  localparam int unsigned NSRC     = 32;            // interrupt sources
  localparam int unsigned LVL_W    = 3;             // priority level width
  localparam int unsigned ID_W     = 5;             // source number width
  localparam int unsigned STK_DEPTH = 8;            // one entry per level

  // register offsets
  localparam logic [9:0] OFS_MODE_BASE = 10'h000;   // source mode 0..31
  localparam logic [9:0] OFS_SVR_BASE  = 10'h080;   // source handler address 0..31
  localparam logic [9:0] OFS_IVR       = 10'h100;   // current vector readout
  localparam logic [9:0] OFS_FVR       = 10'h104;   // fast vector readout
  localparam logic [9:0] OFS_ISR       = 10'h108;   // current source number
  localparam logic [9:0] OFS_IPR       = 10'h10c;   // pending bits
  localparam logic [9:0] OFS_IMR       = 10'h110;   // mask bits
  localparam logic [9:0] OFS_CISR      = 10'h114;   // request line status
  localparam logic [9:0] OFS_IECR      = 10'h120;   // enable command
  localparam logic [9:0] OFS_IDCR      = 10'h124;   // disable command
  localparam logic [9:0] OFS_ICCR      = 10'h128;   // interrupt_clear_command
  localparam logic [9:0] OFS_ISCR      = 10'h12c;   // interrupt_set_command
  localparam logic [9:0] OFS_EOICR     = 10'h130;   // end_of_service_command
  localparam logic [9:0] OFS_SPU       = 10'h134;   // spurious_handler_address
  localparam logic [9:0] OFS_EVT_STAT  = 10'h140;   // event status, read only
  localparam logic [9:0] OFS_EVT_CLR   = 10'h144;   // event clear, write only
  localparam logic [9:0] OFS_EVT_EN    = 10'h148;   // event enable

  // mode register fields
  localparam int unsigned MODE_PRIO_LSB = 0;        // priority level field
  localparam int unsigned MODE_EDGE_BIT = 5;        // 1 = edge triggered

  // event bits
  localparam int unsigned EVT_W        = 3;         // number of events
  localparam int unsigned EVT_TAKEN    = 0;         // vector read took a source
  localparam int unsigned EVT_SPUR     = 1;         // vector read found nothing
  localparam int unsigned EVT_EOS      = 2;         // end of service written

  // reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000; // spurious, vectors, masks
  localparam logic [2:0]  RST_EVT      = 3'h0;          // event registers

  // merge write data into an old word under the byte enables
  function automatic logic [31:0] vipsq_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    return res;
  endfunction

endpackage

// [design/vipsq_core_if.sv]
// Purpose: carries candidate, stack and push/pop signals between sequencer parts
// Assumes: all parts on mclk
// Notes:   ctl is the top, res the resolver, stk the level stack
`timescale 1ns/1ns
`default_nettype none
interface vipsq_core_if;
  import vipsq_pkg::*;
  logic [NSRC-1:0]       pend_vec;   // effective pending and enabled
  logic [NSRC*LVL_W-1:0] lvl_vec;    // priority level of each source
  logic                  cand_valid; // some source 1..31 pending and enabled
  logic [ID_W-1:0]       cand_id;    // highest priority source
  logic [LVL_W-1:0]      cand_lvl;   // its level
  logic                  push;       // push candidate
  logic                  pop;        // pop on end of service
  logic [ID_W-1:0]       push_id;    // id pushed
  logic [LVL_W-1:0]      push_lvl;   // level pushed
  logic [ID_W-1:0]       top_id;     // current interrupt
  logic [LVL_W-1:0]      top_lvl;    // current level
  logic                  empty;      // no current interrupt
  logic [3:0]            depth;      // entries held
  modport ctl (output pend_vec, lvl_vec, push, pop, push_id, push_lvl,
               input cand_valid, cand_id, cand_lvl, top_id, top_lvl, empty, depth);
  modport res (input pend_vec, lvl_vec, output cand_valid, cand_id, cand_lvl);
  modport stk (input push, pop, push_id, push_lvl,
               output top_id, top_lvl, empty, depth);
endinterface
`default_nettype wire

// [design/vipsq_resolver.sv]
// Purpose: picks the highest priority pending source among 1..31
// Assumes: source 0 is the fast line and never competes here
// Notes:   equal levels resolve to the lowest source number
`timescale 1ns/1ns
`default_nettype none
module vipsq_resolver
  import vipsq_pkg::*;
(
  vipsq_core_if.res cif  // candidate side
);

  logic             found;   // any pending seen
  logic [ID_W-1:0]  best_id; // best so far
  logic [LVL_W-1:0] best_lvl; // level of best so far

  // scan upward, replace only on a strictly higher level
  always_comb
  begin
    found    = 1'b0;
    best_id  = '0;
    best_lvl = '0;
    for (int i = 1; i < NSRC; i++)
    begin
      if (cif.pend_vec[i] && (!found || cif.lvl_vec[i*LVL_W +: LVL_W] > best_lvl))
      begin
        found    = 1'b1;
        best_id  = ID_W'(i);
        best_lvl = cif.lvl_vec[i*LVL_W +: LVL_W];
      end
    end
  end

  assign cif.cand_valid = found;
  assign cif.cand_id    = best_id;
  assign cif.cand_lvl   = best_lvl;

endmodule
`default_nettype wire

// [design/vipsq_level_stack.sv]
// Purpose: stack of current levels and source numbers for nested service
// Assumes: push and pop never in the same cycle
// Notes:   push on a full stack and pop on an empty one are ignored
`timescale 1ns/1ns
`default_nettype none
module vipsq_level_stack
  import vipsq_pkg::*;
(
  input  wire logic mclk, // system clock
  input  wire logic rstn, // async reset, active low
  vipsq_core_if.stk cif   // push/pop side
);

  logic [LVL_W-1:0] lvl_mem [STK_DEPTH]; // stacked levels
  logic [ID_W-1:0]  id_mem  [STK_DEPTH]; // stacked source numbers
  logic [3:0]       ptr_reg;             // entries held

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ptr_reg <= 4'h0;
    else if (cif.push && ptr_reg != 4'(STK_DEPTH))
      ptr_reg <= ptr_reg + 4'h1;
    else if (cif.pop && ptr_reg != 4'h0)
      ptr_reg <= ptr_reg - 4'h1;
  end

  // entry storage, written on push
  always_ff @(posedge mclk)
  begin
    if (cif.push && ptr_reg != 4'(STK_DEPTH))
    begin
      lvl_mem[ptr_reg[2:0]] <= cif.push_lvl;
      id_mem[ptr_reg[2:0]]  <= cif.push_id;
    end
  end

  // top of stack, zero when empty
  assign cif.empty   = (ptr_reg == 4'h0);
  assign cif.depth   = ptr_reg;
  assign cif.top_lvl = cif.empty ? '0 : lvl_mem[3'(ptr_reg - 4'h1)];
  assign cif.top_id  = cif.empty ? '0 : id_mem[3'(ptr_reg - 4'h1)];

  AST_STK_BOUND: assert property (@(posedge mclk) disable iff (!rstn)
    ptr_reg <= 4'(STK_DEPTH))
    else $error("level stack overflowed");

  AST_EOS_POP: assert property (@(posedge mclk) disable iff (!rstn)
    cif.pop && !cif.empty |=> ptr_reg == $past(ptr_reg) - 4'h1)
    else $error("end of service did not pop");

  AST_TAKE_PUSH: assert property (@(posedge mclk) disable iff (!rstn)
    cif.push && ptr_reg != 4'(STK_DEPTH) |=> cif.top_id == $past(cif.push_id)
      && cif.top_lvl == $past(cif.push_lvl) && ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("vector read did not push the candidate");

endmodule
`default_nettype wire

// [design/vipsq_top.sv]
// Purpose: command and vector registers and service sequence of the interrupt unit
// Assumes: sources arrive asynchronous, are synchronised here; wishbone on mclk
// Notes:   side effects take place at the edge that raises ack
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - clear command drops pending bits written one
// - set command forces pending bits written one
// - any end of service write ends service
// - spurious handler address register, reset zero
// - vector read makes best pending current
// - vector read drops normal request line
// - vector read clears edge source pending
// - vector read pushes new current level
// - vector read returns current source handler
// - request only above current level, nesting
// - end of service pops level stack
// - after pop, re-raise for higher pending
// - no current interrupt reads vector zero
// - fast vector returns handler zero
module vipsq_top
  import vipsq_pkg::*;
(
  input  wire logic        mclk,              // system clock, 20 MHz
  input  wire logic        rstn,              // async reset, active low
  input  wire logic [9:0]  wb_adr_i,          // byte address
  input  wire logic [31:0] wb_dat_i,          // write data
  output logic      [31:0] wb_dat_o,          // read data
  input  wire logic        wb_we_i,           // write enable
  input  wire logic [3:0]  wb_sel_i,          // byte enables
  input  wire logic        wb_stb_i,          // strobe
  input  wire logic        wb_cyc_i,          // cycle
  output logic             wb_ack_o,          // acknowledge
  input  wire logic [31:0] src_in,            // interrupt sources, async
  output logic             normal_request_line, // request to core, active high
  output logic             fast_request_line, // fast request to core, active high
  output logic             evt_irq            // event interrupt, level
);

  vipsq_core_if cif ();                       // core bundle

  // bus state
  logic        ack_reg;                       // ack flop
  logic [31:0] dat_reg;                       // read data flop
  logic [31:0] rd_next;                       // read mux
  logic        req;                           // new request this cycle
  logic        wr;                            // write request
  logic        rd;                            // read request
  logic [31:0] wmask;                         // write data under byte enables
  // source synchroniser and edge detect
  logic [31:0] src_s1_reg;                    // first stage
  logic [31:0] src_s2_reg;                    // second stage
  logic [31:0] src_s3_reg;                    // edge history
  logic [31:0] rise;                          // rising edge on edge sources
  // register file
  logic [LVL_W-1:0] prio_reg [NSRC];          // source priority
  logic [31:0]      edge_reg;                 // source edge mode
  logic [31:0]      svr_reg [NSRC];           // source handler addresses
  logic [31:0]      spu_reg;                  // spurious_handler_field
  logic [31:0]      mask_reg;                 // enabled sources
  logic [31:0]      pend_reg;                 // latched pending
  logic [31:0]      pend_next;                // next latched pending
  logic [31:0]      pend_eff;                 // latched or live level
  logic [EVT_W-1:0] evt_stat_reg;             // event status
  logic [EVT_W-1:0] evt_en_reg;               // event enable
  logic [EVT_W-1:0] evt_set;                  // event pulses
  logic             spu_wr_seen;              // helper: spurious written
  // sequencing
  logic eligible;                             // candidate above current level
  logic ivr_rd;                               // vector read taken
  logic take;                                 // vector read with a candidate
  logic eos_wr;                               // end of service write
  // request decode, one request per two cycles of a held strobe
  assign req   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr    = req && wb_we_i;
  assign rd    = req && !wb_we_i;
  assign wmask = vipsq_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // two-stage synchroniser and edge history
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_s1_reg <= RST_WORD;
      src_s2_reg <= RST_WORD;
      src_s3_reg <= RST_WORD;
    end
    else
    begin
      src_s1_reg <= src_in;
      src_s2_reg <= src_s1_reg;
      src_s3_reg <= src_s2_reg;
    end
  end

  assign rise     = edge_reg & src_s2_reg & ~src_s3_reg;
  // level sources show their live level, edge sources their latch
  assign pend_eff = pend_reg | (~edge_reg & src_s2_reg);

  // resolver and stack hookup
  always_comb
  begin
    cif.pend_vec = pend_eff & mask_reg;
    for (int i = 0; i < NSRC; i++)
      cif.lvl_vec[i*LVL_W +: LVL_W] = prio_reg[i];
  end

  vipsq_resolver i_vipsq_resolver (
    .cif (cif)
  );
  vipsq_level_stack i_vipsq_level_stack (
    .mclk (mclk),
    .rstn (rstn),
    .cif  (cif)
  );

  assign eligible = cif.cand_valid && (cif.empty || cif.cand_lvl > cif.top_lvl);
  assign normal_request_line = eligible;
  assign fast_request_line   = cif.pend_vec[0];
  assign ivr_rd = rd && (wb_adr_i == OFS_IVR);
  assign take   = ivr_rd && eligible;
  assign eos_wr = wr && (wb_adr_i == OFS_EOICR);

  assign cif.push     = take;
  assign cif.push_id  = cif.cand_id;
  assign cif.push_lvl = cif.cand_lvl;
  assign cif.pop      = eos_wr;

  // read mux
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (wb_adr_i < OFS_SVR_BASE)
    begin
      rd_next[MODE_PRIO_LSB +: LVL_W] = prio_reg[wb_adr_i[6:2]];
      rd_next[MODE_EDGE_BIT]          = edge_reg[wb_adr_i[6:2]];
    end
    else if (wb_adr_i < OFS_IVR)
      rd_next = svr_reg[wb_adr_i[6:2]];
    else if (wb_adr_i == OFS_IVR)
    begin
      // handler of the new current source
      if (eligible)
        rd_next = svr_reg[cif.cand_id];
      else if (cif.empty)
        rd_next = 32'h0000_0000;
      else
        rd_next = spu_reg;
    end
    else if (wb_adr_i == OFS_FVR)
      rd_next = svr_reg[0];
    else if (wb_adr_i == OFS_ISR)
      rd_next[ID_W-1:0] = cif.top_id;
    else if (wb_adr_i == OFS_IPR)
      rd_next = pend_eff;
    else if (wb_adr_i == OFS_IMR)
      rd_next = mask_reg;
    else if (wb_adr_i == OFS_CISR)
      rd_next[1:0] = {normal_request_line, fast_request_line};
    else if (wb_adr_i == OFS_SPU)
      rd_next = spu_reg;
    else if (wb_adr_i == OFS_EVT_STAT)
      rd_next[EVT_W-1:0] = evt_stat_reg;
    else if (wb_adr_i == OFS_EVT_EN)
      rd_next[EVT_W-1:0] = evt_en_reg;
    else
      rd_next = 32'h0000_0000;          // unmapped or write only
  end

  // bus answer, one wait state, ack for every address
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_reg <= 1'b0;
      dat_reg <= RST_WORD;
    end
    else
    begin
      ack_reg <= req;
      if (rd)
        dat_reg <= rd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // source mode and handler address writes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      edge_reg <= RST_WORD;
      for (int i = 0; i < NSRC; i++)
      begin
        prio_reg[i] <= '0;
        svr_reg[i]  <= RST_WORD;
      end
    end
    else if (wr && wb_adr_i < OFS_SVR_BASE)
    begin
      if (wb_sel_i[0])
      begin
        prio_reg[wb_adr_i[6:2]] <= wb_dat_i[MODE_PRIO_LSB +: LVL_W];
        edge_reg[wb_adr_i[6:2]] <= wb_dat_i[MODE_EDGE_BIT];
      end
    end
    else if (wr && wb_adr_i < OFS_IVR)
      svr_reg[wb_adr_i[6:2]] <= vipsq_merge(svr_reg[wb_adr_i[6:2]], wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      spu_reg     <= RST_WORD;
      spu_wr_seen <= 1'b0;
    end
    else if (wr && wb_adr_i == OFS_SPU)
    begin
      spu_reg     <= vipsq_merge(spu_reg, wb_dat_i, wb_sel_i);
      spu_wr_seen <= 1'b1;
    end
  end

  // source enable and disable commands
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mask_reg <= RST_WORD;
    else if (wr && wb_adr_i == OFS_IECR)
      mask_reg <= mask_reg | wmask;
    else if (wr && wb_adr_i == OFS_IDCR)
      mask_reg <= mask_reg & ~wmask;
  end

  // pending next value: clears first, hardware edges win over any clear
  always_comb
  begin
    pend_next = pend_reg;
    if (wr && wb_adr_i == OFS_ICCR)
      pend_next = pend_next & ~wmask;
    if (wr && wb_adr_i == OFS_ISCR)
      pend_next = pend_next | wmask;
    if (take && edge_reg[cif.cand_id])
      pend_next[cif.cand_id] = 1'b0;
    pend_next = pend_next | rise;
  end

  // pending latch
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pend_reg <= RST_WORD;
    else
      pend_reg <= pend_next;
  end

  // event status: sticky, set wins over the clear register
  assign evt_set[EVT_TAKEN] = take;
  assign evt_set[EVT_SPUR]  = ivr_rd && !eligible;
  assign evt_set[EVT_EOS]   = eos_wr;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      evt_stat_reg <= RST_EVT;
      evt_en_reg   <= RST_EVT;
    end
    else
    begin
      if (wr && wb_adr_i == OFS_EVT_CLR)
        evt_stat_reg <= (evt_stat_reg & ~wmask[EVT_W-1:0]) | evt_set;
      else
        evt_stat_reg <= evt_stat_reg | evt_set;
      if (wr && wb_adr_i == OFS_EVT_EN)
        evt_en_reg <= wmask[EVT_W-1:0];
    end
  end

  assign evt_irq = |(evt_stat_reg & evt_en_reg);

  AST_CLR_CMD: assert property (@(posedge mclk) disable iff (!rstn)
    wr && wb_adr_i == OFS_ICCR |=> (pend_reg & $past(wmask & ~rise)) == 32'h0000_0000)
    else $error("clear command left a pending bit");
  AST_SET_CMD: assert property (@(posedge mclk) disable iff (!rstn)
    wr && wb_adr_i == OFS_ISCR |=> (pend_reg & $past(wmask)) == $past(wmask))
    else $error("set command missed a pending bit");
  AST_SPU_RESET: assert property (@(posedge mclk) disable iff (!rstn)
    !spu_wr_seen |-> spu_reg == 32'h0000_0000)
    else $error("spurious address not zero after reset");
  AST_LINE_DROP: assert property (@(posedge mclk) disable iff (!rstn)
    take |=> !normal_request_line || cif.cand_lvl > $past(cif.cand_lvl))
    else $error("request line held after vector read");
  AST_EDGE_CLR: assert property (@(posedge mclk) disable iff (!rstn)
    take && edge_reg[cif.cand_id] && !rise[cif.cand_id] |=> !pend_reg[$past(cif.cand_id)])
    else $error("edge source still pending after vector read");
  AST_VEC_DATA: assert property (@(posedge mclk) disable iff (!rstn)
    take ##1 wb_ack_o |-> wb_dat_o == $past(svr_reg[cif.cand_id]))
    else $error("vector read returned wrong handler");
  AST_NEST_LVL: assert property (@(posedge mclk) disable iff (!rstn)
    normal_request_line |-> cif.pend_vec[cif.cand_id] && (cif.empty || cif.cand_lvl > cif.top_lvl))
    else $error("request line raised at or below current level");
  AST_NONE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    ivr_rd && !eligible && cif.empty |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("vector read with nothing current not zero");
  AST_FAST_VEC: assert property (@(posedge mclk) disable iff (!rstn)
    rd && wb_adr_i == OFS_FVR |=> wb_dat_o == $past(svr_reg[0]))
    else $error("fast vector not handler zero");

  COV_NESTED: cover property (@(posedge mclk) disable iff (!rstn)
    take && !cif.empty);
  COV_SPURIOUS: cover property (@(posedge mclk) disable iff (!rstn)
    ivr_rd && !eligible && !cif.empty);
  COV_REARM: cover property (@(posedge mclk) disable iff (!rstn)
    eos_wr ##1 normal_request_line);

endmodule
`default_nettype wire

// [dv/vipsq_src_model.sv]
// Purpose: interrupt sources seen by the sequencer, driven from the core side
// Assumes: one mclk domain, sources change just after a rising edge
// Notes:   level sources stay raised until the handler removes them
`timescale 1ns/1ns
`default_nettype none
module vipsq_src_model
(
  input  wire logic        mclk,   // system clock
  input  wire logic        rstn,   // async reset, active low
  input  wire logic [31:0] raise,  // conditions asked by the bench
  output logic      [31:0] src_in  // source lines to the sequencer
);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      src_in <= 32'h0;  // all sources quiet
    else
      src_in <= raise;  // follow the handler's wishes
  end
endmodule
`default_nettype wire

// [dv/vipsq_top_tb.sv]
// Purpose: register and service sequence tests of the interrupt sequencer
// Assumes: classic wishbone, ack one cycle after the request is taken
// Notes:   request lines are sampled on the falling edge
`timescale 1ns/1ns
`default_nettype none
module vipsq_top_tb;
  import vipsq_pkg::*;
  logic        mclk = 1'b0;      // system clock
  logic        rstn = 1'b0;      // reset, active low
  logic [9:0]  adr  = 10'h0;     // bus address
  logic [31:0] dw   = 32'h0;     // write data
  logic [31:0] dr;               // read data
  logic        we   = 1'b0;      // write enable
  logic [3:0]  sel  = 4'hf;      // byte enables
  logic        stb  = 1'b0;      // strobe
  logic        cyc  = 1'b0;      // cycle
  logic        ack;              // acknowledge
  logic [31:0] raise = 32'h0;    // wanted source levels
  logic [31:0] src;              // source lines
  logic        nrl, frl, eirq;   // request outputs
  logic [31:0] q;                // last read word
  int          n_fail = 0;       // mismatches
  int          checks = 0;       // comparisons
  int          ids [5] = '{0, 3, 5, 7, 9};           // sources used
  logic [7:0]  mds [5] = '{8'h20, 8'h22, 8'h26, 8'h24, 8'h01}; // their modes

  always #25 mclk = ~mclk;  // 20 MHz

  vipsq_top i_vipsq_top (.mclk(mclk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc),
    .wb_ack_o(ack), .src_in(src), .normal_request_line(nrl),
    .fast_request_line(frl), .evt_irq(eirq));
  vipsq_src_model i_vipsq_src_model (.mclk(mclk), .rstn(rstn), .raise(raise), .src_in(src));

  // handler address chosen for source n
  function automatic logic [31:0] hv(input int n);
    return 32'ha000_0000 | 32'(n);
  endfunction

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic bus cycle, bounded wait for ack
  task automatic wb(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    we  <= w;
    dw  <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      $display("[ERR] ack expected 1 seen timeout");
      test_done();
    end
  endtask

  // read and compare
  task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(nm, q, e);
  endtask

  // compare a request line once settled
  task automatic lc(input string nm, input logic v, input logic e);
    @(negedge mclk);
    chk(nm, {31'h0, v}, {31'h0, e});
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rc("spu", OFS_SPU, 32'h0);
    wb(OFS_SPU, 1'b1, 32'h1234_5678);
    rc("spu", OFS_SPU, 32'h1234_5678);
    rc("ivr", OFS_IVR, 32'h0);
    rc("unmapped", 10'h3fc, 32'h0);
    $display("test regs done");
    foreach (ids[i])
    begin
      wb(OFS_MODE_BASE + 10'(4 * ids[i]), 1'b1, {24'h0, mds[i]});
      wb(OFS_SVR_BASE + 10'(4 * ids[i]), 1'b1, hv(ids[i]));
    end
    wb(OFS_IECR, 1'b1, 32'h0000_02a9);
    wb(OFS_ISCR, 1'b1, 32'h0000_0028);
    rc("ipr", OFS_IPR, 32'h0000_0028);
    wb(OFS_ICCR, 1'b1, 32'h0000_0020);
    rc("ipr", OFS_IPR, 32'h0000_0008);
    wb(OFS_ISCR, 1'b1, 32'h0000_0020);
    lc("nrl", nrl, 1'b1);
    rc("ivr", OFS_IVR, hv(5));
    lc("nrl", nrl, 1'b0);
    rc("ipr", OFS_IPR, 32'h0000_0008);
    rc("isr", OFS_ISR, 32'h5);
    wb(OFS_ISCR, 1'b1, 32'h0000_0080);
    lc("nrl", nrl, 1'b0);
    wb(OFS_EOICR, 1'b1, 32'hdead_beef);
    rc("isr", OFS_ISR, 32'h0);
    lc("nrl", nrl, 1'b1);
    $display("test service done");
    rc("ivr", OFS_IVR, hv(7));
    wb(OFS_ISCR, 1'b1, 32'h0000_0020);
    lc("nrl", nrl, 1'b1);
    rc("ivr", OFS_IVR, hv(5));
    wb(OFS_EOICR, 1'b1, 32'h0);
    rc("isr", OFS_ISR, 32'h7);
    lc("nrl", nrl, 1'b0);
    wb(OFS_EOICR, 1'b1, 32'h0);
    lc("nrl", nrl, 1'b1);
    rc("ivr", OFS_IVR, hv(3));
    wb(OFS_EOICR, 1'b1, 32'h0);
    $display("test nesting done");
    wb(OFS_ISCR, 1'b1, 32'h0000_0001);
    lc("frl", frl, 1'b1);
    rc("cisr", OFS_CISR, 32'h0000_0001);
    rc("fvr", OFS_FVR, hv(0));
    wb(OFS_ICCR, 1'b1, 32'h0000_0001);
    lc("frl", frl, 1'b0);
    $display("test fast done");
    @(posedge mclk);
    raise <= 32'h0000_0200;
    repeat (4) @(posedge mclk);
    lc("nrl", nrl, 1'b1);
    rc("ivr", OFS_IVR, hv(9));
    lc("nrl", nrl, 1'b0);
    rc("ipr", OFS_IPR, 32'h0000_0200);
    rc("ivr", OFS_IVR, 32'h1234_5678);
    raise <= 32'h0;
    repeat (4) @(posedge mclk);
    wb(OFS_ICCR, 1'b1, 32'h0000_0200);
    // source cleared, then end of service
    wb(OFS_EOICR, 1'b1, 32'h0);
    rc("ipr", OFS_IPR, 32'h0);
    lc("nrl", nrl, 1'b0);
    wb(OFS_IDCR, 1'b1, 32'h0000_0008);
    rc("imr", OFS_IMR, 32'h0000_02a1);
    $display("test level done");
    rc("evt", OFS_EVT_STAT, 32'h7);
    lc("eirq", eirq, 1'b0);
    wb(OFS_EVT_EN, 1'b1, 32'h7);
    lc("eirq", eirq, 1'b1);
    wb(OFS_EVT_CLR, 1'b1, 32'h7);
    lc("eirq", eirq, 1'b0);
    $display("test events done");
    test_done();
  end
endmodule
`default_nettype wire
